//--- src/isc_stats.sv
/*
 * Interface statistics counters for the wired and wireless MACs.
 * Assumes all event inputs are one-cycle pulses or levels from MAC
 * logic on clk; the management side polls through the read port.
 */
`include "isc_defs.svh"

module isc_stats (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Ethernet MAC events
    input wire isc_pkg::isc_erx_s ethRx,
    input wire isc_pkg::isc_etx_s ethTx,
    input wire isc_pkg::isc_host_s ethHost,
    input wire logic [`ISC_OCT_W-1:0] maxFrameLen,
    // Wireless MAC events
    input wire isc_pkg::isc_wtx_s wlanTx,
    input wire isc_pkg::isc_host_s wlanHost,
    // Desired state and link
    input wire isc_pkg::isc_ifst_e ethAdmin,
    input wire isc_pkg::isc_ifst_e wlanAdmin,
    input wire logic ethLinkUp,
    input wire logic wlanLinkUp,
    // Reported state
    output isc_pkg::isc_ifst_e ethAdminSt,
    output isc_pkg::isc_ifst_e ethOperSt,
    output isc_pkg::isc_ifst_e wlanAdminSt,
    output isc_pkg::isc_ifst_e wlanOperSt,
    // Counter read port
    input wire logic rdReq,
    input wire logic [`ISC_IDX_W-1:0] rdIdx,
    output logic rdValid,
    output logic [`ISC_CTR_W-1:0] rdData
);

    localparam int N = `ISC_CTR_NUM;

    // =================================================================
    // Declarations
    isc_pkg::isc_txst_e state_r;
    isc_pkg::isc_txst_e state_nxt;
    logic [1:0] collCnt_r;
    logic [`ISC_BIT_CNT_W-1:0] bitCnt_r;
    logic deferSeen_r;
    logic firstTry_r;
    logic lateSeen_r;
    logic cseSeen_r;
    logic carrSeen_r;
    logic cseAtt_r;
    logic inSend;
    logic inWait;
    logic attemptEnd;
    logic lateNow;
    logic cseInc;
    logic lateInc;
    logic endOk;
    logic endExc;
    logic endFail;
    logic tooLong;
    logic [N-1:0] inc;
    logic [N-1:0][`ISC_OCT_W-1:0] amt;
    logic [8:0] ethHv;
    logic [8:0] wlanHv;
    logic [7:0] wlanInc;
    isc_pkg::isc_ifst_e ethAdmin_r;
    isc_pkg::isc_ifst_e ethOper_r;
    isc_pkg::isc_ifst_e wlanAdmin_r;
    isc_pkg::isc_ifst_e wlanOper_r;

    // =================================================================
    // Functions
    // Host-layer counters, in the order of the index map
    function automatic logic [8:0] hostVec(isc_pkg::isc_host_s h);
        logic [8:0] v;
        v[0] = h.inOctEn;
        v[1] = h.outOctEn;
        v[2] = h.inDeliver && h.inUnicast;
        v[3] = h.inDeliver && !h.inUnicast;
        v[4] = h.outReq && h.outUnicast;
        v[5] = h.outReq && !h.outUnicast;
        v[6] = h.inDiscard;
        v[7] = h.outDiscard;
        v[8] = h.inUnknown;
        return v;
    endfunction

    // Current state follows the desired one, gated by the link
    function automatic isc_pkg::isc_ifst_e operOf(
        isc_pkg::isc_ifst_e adm, logic link);
        isc_pkg::isc_ifst_e s;
        case (adm)
            isc_pkg::IF_TEST: s = isc_pkg::IF_TEST;
            isc_pkg::IF_UP: s = link ? isc_pkg::IF_UP : isc_pkg::IF_DOWN;
            default: s = isc_pkg::IF_DOWN;
        endcase
        return s;
    endfunction

    // =================================================================
    // Transmit tracker decode
    assign inSend = (state_r == isc_pkg::ST_SEND);
    assign inWait = (state_r == isc_pkg::ST_WAIT);
    assign lateNow = (bitCnt_r >= `ISC_LATE_BITS);

    // Any outcome closes the running attempt
    assign attemptEnd = inSend && (ethTx.collision || ethTx.ok ||
                                   ethTx.excess || ethTx.macFail);

    // Drop after carrier seen, or none by the end; once per attempt
    assign cseInc = inSend && !cseAtt_r && !ethTx.carrier &&
                    (carrSeen_r || attemptEnd);

    assign lateInc = inSend && ethTx.collision && lateNow;

    // Abandon and failure may come while waiting after a collision
    assign endOk = inSend && ethTx.ok;
    assign endExc = (inSend || inWait) && ethTx.excess;
    assign endFail = (inSend || inWait) && ethTx.macFail;

    // =================================================================
    // Transmit tracker state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            isc_pkg::ST_IDLE: begin
                if (ethTx.frameStart) begin
                    state_nxt = isc_pkg::ST_WAIT;
                end
            end
            isc_pkg::ST_WAIT: begin
                if (endExc || endFail) begin
                    state_nxt = isc_pkg::ST_IDLE;
                end else if (ethTx.attemptStart) begin
                    state_nxt = isc_pkg::ST_SEND;
                end
            end
            isc_pkg::ST_SEND: begin
                if (endOk || endExc || endFail) begin
                    state_nxt = isc_pkg::ST_IDLE;
                end else if (ethTx.collision) begin
                    state_nxt = isc_pkg::ST_WAIT;
                end
            end
            default: state_nxt = isc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= isc_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Collisions per frame, held at three so two-or-more stays true
    always_ff @(posedge clk) begin
        if (reset || ethTx.frameStart) begin
            collCnt_r <= 2'h0;
        end else if (inSend && ethTx.collision && collCnt_r != 2'h3) begin
            collCnt_r <= collCnt_r + 2'h1;
        end
    end

    // Bit-times into the attempt; saturates at the late threshold
    always_ff @(posedge clk) begin
        if (reset || (inWait && ethTx.attemptStart)) begin
            bitCnt_r <= '0;
        end else if (inSend && ethTx.bitTick && !lateNow) begin
            bitCnt_r <= bitCnt_r + `ISC_BIT_CNT_W'(1);
        end
    end

    // Busy medium is noted only ahead of the first attempt
    always_ff @(posedge clk) begin
        if (reset || ethTx.frameStart) begin
            deferSeen_r <= 1'b0;
            firstTry_r <= 1'b1;
        end else begin
            if (inWait && firstTry_r && ethTx.busy) begin
                deferSeen_r <= 1'b1;
            end
            if (inWait && ethTx.attemptStart) begin
                firstTry_r <= 1'b0;
            end
        end
    end

    // Per-attempt carrier history
    always_ff @(posedge clk) begin
        if (reset || (inWait && ethTx.attemptStart)) begin
            carrSeen_r <= 1'b0;
            cseAtt_r <= 1'b0;
        end else if (inSend) begin
            if (ethTx.carrier) begin
                carrSeen_r <= 1'b1;
            end
            if (cseInc) begin
                cseAtt_r <= 1'b1;
            end
        end
    end

    // Per-frame history that keeps a failure out of the generic count
    always_ff @(posedge clk) begin
        if (reset || ethTx.frameStart) begin
            lateSeen_r <= 1'b0;
            cseSeen_r <= 1'b0;
        end else begin
            if (lateInc) begin
                lateSeen_r <= 1'b1;
            end
            if (cseInc) begin
                cseSeen_r <= 1'b1;
            end
        end
    end

    // =================================================================
    // Receive classification; length is checked first so that an
    // oversize frame lands only in the too-long and total error counters
    assign tooLong = ethRx.done && (ethRx.len > maxFrameLen);

    // =================================================================
    // Increment assembly
    assign ethHv = hostVec(ethHost);
    assign wlanHv = hostVec(wlanHost);

    always_comb begin
        inc = '0;
        for (int i = 0; i < N; i++) begin
            amt[i] = `ISC_OCT_W'(1);
        end
        // Ethernet receive errors, exclusive apart from the C_EINERR total
        inc[isc_pkg::C_TOOLONG] = tooLong;
        inc[isc_pkg::C_ALIGN] = ethRx.done && !tooLong &&
                                !ethRx.fcsOk && !ethRx.whole;
        inc[isc_pkg::C_FCS] = ethRx.done && !tooLong &&
                              !ethRx.fcsOk && ethRx.whole;
        inc[isc_pkg::C_MACRX] = ethRx.done && !tooLong &&
                                ethRx.fcsOk && ethRx.macErr;
        inc[isc_pkg::C_EINERR] = ethRx.done && (tooLong ||
                                 !ethRx.fcsOk || ethRx.macErr);
        // Ethernet transmit outcomes
        inc[isc_pkg::C_CSE] = cseInc;
        inc[isc_pkg::C_LATE] = lateInc;
        inc[isc_pkg::C_SINGLE] = endOk && (collCnt_r == 2'h1);
        inc[isc_pkg::C_MULTI] = endOk && (collCnt_r >= 2'h2);
        inc[isc_pkg::C_DEFER] = endOk && (collCnt_r == 2'h0) &&
                                deferSeen_r;
        inc[isc_pkg::C_EXCESS] = endExc;
        inc[isc_pkg::C_MACTX] = endFail && !endExc && !lateSeen_r &&
                                !lateInc && !cseSeen_r &&
                                !cseInc;
        inc[isc_pkg::C_EOUTERR] = endExc || endFail;
        // Host-layer counters of both interfaces
        for (int k = 0; k < 9; k++) begin
            inc[int'(isc_pkg::C_EINOCT) + k] = ethHv[k];
            inc[int'(isc_pkg::C_WINOCT) + k] = wlanHv[k];
        end
        amt[isc_pkg::C_EINOCT] = ethHost.inOct;
        amt[isc_pkg::C_EOUTOCT] = ethHost.outOct;
        amt[isc_pkg::C_WINOCT] = wlanHost.inOct;
        amt[isc_pkg::C_WOUTOCT] = wlanHost.outOct;
        // Wireless MAC outcomes
        for (int k = 0; k < 8; k++) begin
            inc[int'(isc_pkg::C_RTSFAIL) + k] = wlanInc[k];
        end
    end

    isc_wlan_class u_wlan (
        .ev(wlanTx),
        .inc(wlanInc)
    );

    isc_ctr_bank #(
        .N(N)
    ) u_bank (
        .clk(clk),
        .reset(reset),
        .inc(inc),
        .amt(amt),
        .rdReq(rdReq),
        .rdIdx(rdIdx),
        .rdValid(rdValid),
        .rdData(rdData)
    );

    // =================================================================
    // Interface state; one cycle behind the inputs
    always_ff @(posedge clk) begin
        if (reset) begin
            ethAdmin_r <= isc_pkg::IF_DOWN;
            ethOper_r <= isc_pkg::IF_DOWN;
            wlanAdmin_r <= isc_pkg::IF_DOWN;
            wlanOper_r <= isc_pkg::IF_DOWN;
        end else begin
            ethAdmin_r <= ethAdmin;
            ethOper_r <= operOf(ethAdmin, ethLinkUp);
            wlanAdmin_r <= wlanAdmin;
            wlanOper_r <= operOf(wlanAdmin, wlanLinkUp);
        end
    end

    assign ethAdminSt = ethAdmin_r;
    assign ethOperSt = ethOper_r;
    assign wlanAdminSt = wlanAdmin_r;
    assign wlanOperSt = wlanOper_r;

    // =================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_align_class: assert property (
        (ethRx.done && !ethRx.fcsOk && !tooLong) |->
        (inc[isc_pkg::C_ALIGN] == !ethRx.whole) &&
        (inc[isc_pkg::C_FCS] == ethRx.whole))
        else $error("receive error misclassified");

    a_cse_once: assert property (
        cseInc |=> !cseInc)
        else $error("carrier error counted twice");

    a_defer_clean: assert property (
        inc[isc_pkg::C_DEFER] |-> (collCnt_r == 2'h0) && deferSeen_r)
        else $error("deferral counted for collided frame");

    a_late_early: assert property (
        (!inSend ##1 inSend) |-> !inc[isc_pkg::C_LATE] [*8])
        else $error("late collision before 512 bit-times");

    a_coll_split: assert property (
        endOk |-> $countones({inc[isc_pkg::C_SINGLE],
                   inc[isc_pkg::C_MULTI],
                   (collCnt_r == 2'h0)}) == 1)
        else $error("collision class not unique");

    a_mactx_excl: assert property (
        inc[isc_pkg::C_MACTX] |-> !inc[isc_pkg::C_EXCESS] &&
        !inc[isc_pkg::C_LATE] && !inc[isc_pkg::C_CSE] &&
        !lateSeen_r && !cseSeen_r)
        else $error("transmit error counted twice");

    a_macrx_excl: assert property (
        inc[isc_pkg::C_MACRX] |-> !inc[isc_pkg::C_TOOLONG] &&
        !inc[isc_pkg::C_ALIGN] && !inc[isc_pkg::C_FCS])
        else $error("receive error counted twice");

    a_nuc_deliver: assert property (
        (inc[isc_pkg::C_EINNUC] || inc[isc_pkg::C_WINNUC]) |->
        (ethHost.inDeliver || wlanHost.inDeliver))
        else $error("undelivered packet counted");

    a_oper_down: assert property (
        (ethAdmin == isc_pkg::IF_DOWN ||
         (ethAdmin == isc_pkg::IF_UP && !ethLinkUp)) |=>
        ethOperSt == isc_pkg::IF_DOWN)
        else $error("operational state not down");

    a_retry_nest: assert property (
        inc[isc_pkg::C_MRETRY] |-> inc[isc_pkg::C_RETRY])
        else $error("multiple retry without retry");

    a_read_lat: assert property (
        rdReq |=> rdValid ##1 (rdValid == $past(rdReq)))
        else $error("read answer not one cycle later");

endmodule

//--- src/isc_defs.svh
/*
 * Shared constants of the interface statistics counter block: widths,
 * counter count, late collision threshold and interface state codes.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH

// =====================================================================
// Counter geometry
`define ISC_CTR_W 32
`define ISC_CTR_NUM 39
`define ISC_IDX_W 6
`define ISC_OCT_W 16
`define ISC_CTR_RST 32'h0000_0000

// =====================================================================
// Transmit timing
`define ISC_LATE_BITS 10'h200
`define ISC_BIT_CNT_W 10

// =====================================================================
// Interface state codes
`define ISC_ST_UP 2'h1
`define ISC_ST_DOWN 2'h2
`define ISC_ST_TEST 2'h3

`endif

//--- src/isc_pkg.sv
/*
 * Types of the statistics block: event carriers, interface states,
 * transmit tracker states and the counter index map.
 * Assumes isc_defs.svh is on the include path.
 */
`include "isc_defs.svh"

package isc_pkg;

    // =================================================================
    // Interface state, desired and current
    typedef enum logic [1:0] {
        IF_UP = `ISC_ST_UP,
        IF_DOWN = `ISC_ST_DOWN,
        IF_TEST = `ISC_ST_TEST
    } isc_ifst_e;

    // =================================================================
    // Ethernet transmit tracker states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_SEND = 3'b100
    } isc_txst_e;

    // =================================================================
    // Counter index map
    typedef enum logic [`ISC_IDX_W-1:0] {
        C_ALIGN, C_FCS, C_CSE, C_DEFER, C_LATE, C_SINGLE, C_MULTI,
        C_EXCESS, C_MACTX, C_MACRX, C_TOOLONG, C_EINERR, C_EOUTERR,
        C_EINOCT, C_EOUTOCT, C_EINUC, C_EINNUC, C_EOUTUC, C_EOUTNUC,
        C_EINDISC, C_EOUTDISC, C_EUNKP,
        C_WINOCT, C_WOUTOCT, C_WINUC, C_WINNUC, C_WOUTUC, C_WOUTNUC,
        C_WINDISC, C_WOUTDISC, C_WUNKP,
        C_RTSFAIL, C_RTSOK, C_RETRY, C_MRETRY, C_ACKFAIL, C_FAILED,
        C_WFCS, C_WEPBAD
    } isc_ctr_e;

    // =================================================================
    // Event carriers
    typedef struct packed {
        logic done;
        logic whole;
        logic fcsOk;
        logic macErr;
        logic [`ISC_OCT_W-1:0] len;
    } isc_erx_s;

    typedef struct packed {
        logic frameStart;
        logic attemptStart;
        logic busy;
        logic carrier;
        logic bitTick;
        logic collision;
        logic ok;
        logic excess;
        logic macFail;
    } isc_etx_s;

    typedef struct packed {
        logic inOctEn;
        logic [`ISC_OCT_W-1:0] inOct;
        logic outOctEn;
        logic [`ISC_OCT_W-1:0] outOct;
        logic inDeliver;
        logic inUnicast;
        logic inDiscard;
        logic inUnknown;
        logic outReq;
        logic outUnicast;
        logic outDiscard;
    } isc_host_s;

    typedef struct packed {
        logic rtsDone;
        logic ctsRcvd;
        logic txOk;
        logic [3:0] retries;
        logic ackMiss;
        logic abandon;
        logic rxFcsErr;
        logic wepBad;
    } isc_wtx_s;

endpackage

//--- src/isc_ctr_bank.sv
/*
 * Bank of wrapping counters with a registered read port.
 * Assumes increment requests and amounts come from logic on clk.
 */
`include "isc_defs.svh"

module isc_ctr_bank #(
    parameter int N = `ISC_CTR_NUM,
    parameter int W = `ISC_CTR_W,
    parameter int AW = `ISC_OCT_W,
    parameter int IW = `ISC_IDX_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Increment requests
    input wire logic [N-1:0] inc,
    input wire logic [N-1:0][AW-1:0] amt,
    // Read port
    input wire logic rdReq,
    input wire logic [IW-1:0] rdIdx,
    output logic rdValid,
    output logic [W-1:0] rdData
);

    logic [W-1:0] cnt [N];

    // Modulo add; the carry out is dropped so the count wraps
    function automatic logic [W-1:0] wrapAdd(logic [W-1:0] a,
                                             logic [AW-1:0] b);
        return a + W'(b);
    endfunction

    // =================================================================
    // Counters
    always_ff @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                cnt[i] <= `ISC_CTR_RST;
            end else if (inc[i]) begin
                cnt[i] <= wrapAdd(cnt[i], amt[i]);
            end
        end
    end

    // Read returns the value before any same-cycle increment
    always_ff @(posedge clk) begin
        if (reset) begin
            rdValid <= 1'b0;
            rdData <= `ISC_CTR_RST;
        end else begin
            rdValid <= rdReq;
            if (rdReq && int'(rdIdx) < N) begin
                rdData <= cnt[rdIdx];
            end else begin
                rdData <= `ISC_CTR_RST;
            end
        end
    end

endmodule

//--- src/isc_wlan_class.sv
/*
 * Classifies wireless MAC outcome pulses into counter increments.
 * Assumes one pulse per outcome, from logic on the same clock.
 * Output bit order follows the wireless MAC entries of the index map.
 */
module isc_wlan_class (
    // Wireless MAC outcomes
    input wire isc_pkg::isc_wtx_s ev,
    // Increments, RTS fail first, undecryptable last
    output logic [7:0] inc
);

    // =================================================================
    // Outcome decode
    always_comb begin
        inc[0] = ev.rtsDone && !ev.ctsRcvd;
        inc[1] = ev.rtsDone && ev.ctsRcvd;
        inc[2] = ev.txOk && (ev.retries != 4'h0);
        inc[3] = ev.txOk && (ev.retries > 4'h1);
        inc[4] = ev.ackMiss;
        inc[5] = ev.abandon;
        inc[6] = ev.rxFcsErr;
        inc[7] = ev.wepBad;
    end

endmodule

//--- sim/isc_mac_model.sv
/*
 * Behavioural wired MAC transmit side: plays one frame per go pulse.
 * Assumes go is a one-cycle pulse and the bench waits on done.
 */
module isc_mac_model (
    // Clock and command
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] nColl,
    input wire logic [9:0] ticks,
    input wire logic defer,
    input wire logic carr,
    input wire logic [1:0] kind,
    // Events to the block
    output isc_pkg::isc_etx_s tx,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;

    // =================================================================
    // One attempt: start, bit-times, then collision or success
    task automatic att(input logic fin);
        tx.attemptStart <= 1'b1;
        @(posedge clk) tx.attemptStart <= 1'b0;
        tx.carrier <= carr;
        tx.bitTick <= 1'b1;
        repeat (ticks) @(posedge clk);
        tx.bitTick <= 1'b0;
        tx.ok <= fin;
        tx.collision <= !fin;
        // Carrier released with the attempt, never left floating high
        @(posedge clk) tx.ok <= 1'b0;
        tx.collision <= 1'b0;
        tx.carrier <= 1'b0;
    endtask

    // =================================================================
    // Frame sequencer; failure kinds end in the waiting state
    initial begin
        tx = '0;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                done <= 1'b0;
                tx.frameStart <= 1'b1;
                @(posedge clk) tx.frameStart <= 1'b0;
                tx.busy <= defer;
                @(posedge clk) tx.busy <= 1'b0;
                repeat (nColl) att(1'b0);
                if (kind == 2'd0) att(1'b1);
                else begin
                    tx.excess <= (kind == 2'd1);
                    tx.macFail <= (kind == 2'd2);
                    @(posedge clk) tx.excess <= 1'b0;
                    tx.macFail <= 1'b0;
                end
                done <= 1'b1;
            end
        end
    end
endmodule

//--- sim/isc_stats_tb_top.sv
/*
 * Self-checking bench of the statistics block with a MAC model.
 * Assumes the package and the block are compiled before this file.
 */
module isc_stats_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, rdReq, rdValid, ethLinkUp, wlanLinkUp;
    logic go, defer, carr, done;
    logic [5:0] rdIdx;
    logic [31:0] rdData;
    logic [15:0] maxFrameLen;
    logic [3:0] nColl;
    logic [9:0] ticks;
    logic [1:0] kind;
    isc_pkg::isc_erx_s ethRx;
    isc_pkg::isc_etx_s ethTx;
    isc_pkg::isc_host_s ethHost, wlanHost, h;
    isc_pkg::isc_wtx_s wlanTx;
    isc_pkg::isc_ifst_e ethAdmin, wlanAdmin, a;
    isc_pkg::isc_ifst_e ethAdminSt, ethOperSt, wlanAdminSt, wlanOperSt;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;

    isc_stats DUT (.clk(clk), .reset(reset), .ethRx(ethRx),
        .ethTx(ethTx), .ethHost(ethHost), .maxFrameLen(maxFrameLen),
        .wlanTx(wlanTx), .wlanHost(wlanHost), .ethAdmin(ethAdmin),
        .wlanAdmin(wlanAdmin), .ethLinkUp(ethLinkUp),
        .wlanLinkUp(wlanLinkUp), .ethAdminSt(ethAdminSt),
        .ethOperSt(ethOperSt), .wlanAdminSt(wlanAdminSt),
        .wlanOperSt(wlanOperSt), .rdReq(rdReq), .rdIdx(rdIdx),
        .rdValid(rdValid), .rdData(rdData));
    isc_mac_model MAC (.clk(clk), .go(go), .nColl(nColl),
        .ticks(ticks), .defer(defer), .carr(carr), .kind(kind),
        .tx(ethTx), .done(done));

    // =================================================================
    // Checking and bus helpers
    task complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, exp, got);
        end
    endtask
    // Read answers exactly one cycle after the request edge
    task rd(input int k, input logic [31:0] exp);
        @(posedge clk) rdReq <= 1'b1;
        rdIdx <= k[5:0];
        @(posedge clk) rdReq <= 1'b0;
        #1 chk("rdValid", 32'(rdValid), 32'h1);
        chk($sformatf("ctr %0d", k), rdData, exp);
    endtask
    task erx(input logic w, f, m, input logic [15:0] n);
        @(posedge clk) ethRx <= '{1'b1, w, f, m, n};
        @(posedge clk) ethRx <= '0;
    endtask
    task hp(input int w);
        @(posedge clk);
        if (w == 1) wlanHost <= h;
        else ethHost <= h;
        @(posedge clk);
        wlanHost <= '0;
        ethHost <= '0;
    endtask
    // One frame through the model; waits under a bound for its end
    task fr(input int n, t, d, c, k);
        int j;
        @(posedge clk) go <= 1'b1;
        {nColl, ticks, defer, carr, kind} <= {4'(n), 10'(t), 1'(d),
            1'(c), 2'(k)};
        @(posedge clk) go <= 1'b0;
        j = 0;
        do begin
            @(posedge clk);
            #1 j++;
        end while (!done && j < 4000);
        // A frame that never ends is a failure, not a silent skip
        if (!done) num_errors++;
    endtask

    // =================================================================
    // Scenarios
    task t_rx();
        erx(1'b0, 1'b0, 1'b0, 16'h0040);
        erx(1'b1, 1'b0, 1'b0, 16'h05DC); // Length at the limit
        erx(1'b0, 1'b0, 1'b0, 16'h05DD); // Long beats alignment
        erx(1'b1, 1'b1, 1'b1, 16'h0040);
        erx(1'b1, 1'b1, 1'b0, 16'h0040);
        rd(isc_pkg::C_ALIGN, 32'h1);
        rd(isc_pkg::C_FCS, 32'h1);
        rd(isc_pkg::C_TOOLONG, 32'h1);
        rd(isc_pkg::C_MACRX, 32'h1);
        rd(isc_pkg::C_EINERR, 32'h4);
    endtask
    task t_tx();
        fr(0, 8, 1, 1, 0);
        fr(1, 8, 1, 1, 0); // Deferred but collided
        fr(2, 8, 0, 1, 0);
        fr(3, 511, 0, 1, 1); // One bit-time short of late
        fr(0, 8, 0, 1, 2);
        fr(1, 512, 0, 1, 2); // Late collision then failure
        fr(0, 8, 0, 0, 0);
        rd(isc_pkg::C_DEFER, 32'h1);
        rd(isc_pkg::C_SINGLE, 32'h1);
        rd(isc_pkg::C_MULTI, 32'h1);
        rd(isc_pkg::C_EXCESS, 32'h1);
        rd(isc_pkg::C_LATE, 32'h1);
        rd(isc_pkg::C_MACTX, 32'h1);
        rd(isc_pkg::C_CSE, 32'h1);
        rd(isc_pkg::C_EOUTERR, 32'h3);
    endtask
    // Wired then wireless; the two maps sit 9 entries apart
    task t_host();
        for (int w = 0; w < 2; w++) begin
            h = '{inOctEn:1, inOct:16'hFFFF, outOctEn:1, outOct:16'h0040,
                inDeliver:1, inUnicast:1, outReq:1, outUnicast:1, default:0};
            hp(w);
            h = '{inOctEn:1, inOct:16'hFFFF, inDeliver:1, outReq:1,
                default:0};
            hp(w);
            h = '{inUnicast:1, inDiscard:1, inUnknown:1, outDiscard:1,
                default:0};
            hp(w);
            rd(isc_pkg::C_EINOCT + w * 9, 32'h0001_FFFE);
            rd(isc_pkg::C_EOUTOCT + w * 9, 32'h0040);
            rd(isc_pkg::C_EINUC + w * 9, 32'h1);
            rd(isc_pkg::C_EINNUC + w * 9, 32'h1);
            rd(isc_pkg::C_EOUTUC + w * 9, 32'h1);
            rd(isc_pkg::C_EOUTNUC + w * 9, 32'h1);
            rd(isc_pkg::C_EINDISC + w * 9, 32'h1);
            rd(isc_pkg::C_EOUTDISC + w * 9, 32'h1);
            rd(isc_pkg::C_EUNKP + w * 9, 32'h1);
        end
    endtask
    // Bits: rts, cts, ok, retries[3:0], ackMiss, abandon, fcs, wep
    task automatic t_wlan();
        logic [10:0] wv[9] = '{11'h600, 11'h400, 11'h100, 11'h110,
            11'h120, 11'h008, 11'h004, 11'h002, 11'h001};
        foreach (wv[i]) begin
            @(posedge clk) wlanTx <= wv[i];
            @(posedge clk) wlanTx <= '0;
        end
        rd(isc_pkg::C_RTSFAIL, 32'h1);
        rd(isc_pkg::C_RTSOK, 32'h1);
        rd(isc_pkg::C_RETRY, 32'h2);
        rd(isc_pkg::C_MRETRY, 32'h1);
        rd(isc_pkg::C_ACKFAIL, 32'h1);
        rd(isc_pkg::C_FAILED, 32'h1);
        rd(isc_pkg::C_WFCS, 32'h1);
        rd(isc_pkg::C_WEPBAD, 32'h1);
    endtask
    // Every desired state against both link levels
    task t_state();
        for (int i = 0; i < 6; i++) begin
            a = isc_pkg::isc_ifst_e'(i % 3 + 1);
            @(posedge clk) ethAdmin <= a;
            wlanAdmin <= a;
            {ethLinkUp, wlanLinkUp} <= {i > 2, i < 3};
            @(posedge clk);
            #1 chk("ethAdminSt", 32'(ethAdminSt), 32'(a));
            chk("ethOperSt", 32'(ethOperSt), oper(i > 2));
            chk("wlanAdminSt", 32'(wlanAdminSt), 32'(a));
            chk("wlanOperSt", 32'(wlanOperSt), oper(i < 3));
        end
    endtask
    // Mid-run reset must clear what the earlier scenarios counted
    task t_clear();
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        rd(isc_pkg::C_EINOCT, 32'h0);
    endtask
    function automatic logic [31:0] oper(input logic l);
        return 32'((a == isc_pkg::IF_UP && !l) ? isc_pkg::IF_DOWN : a);
    endfunction

    // =================================================================
    // Clock, hang guard and main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        {reset, rdReq, rdIdx, go, nColl, ticks, defer, carr, kind} = '1;
        {rdReq, go} = '0;
        {ethRx, wlanTx, ethHost, wlanHost, h} = '0;
        {ethLinkUp, wlanLinkUp} = '0;
        ethAdmin = isc_pkg::IF_UP;
        wlanAdmin = isc_pkg::IF_UP;
        maxFrameLen = 16'h05DC;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_rx();
        t_tx();
        t_host();
        t_wlan();
        t_state();
        t_clear();
        complete_run();
    end
endmodule
